// *** bench/ctp_far_side.sv ***
// Purpose: prescaler taps and count pins
// Assumes: taps are one-cycle enables
// Notes:   pins toggle freely
`timescale 1ns/1ps
`default_nettype none
module ctp_far_side (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    output logic      [7:0] tap_high,
    output logic            tap_low,
    output logic            tap_low_div8,
    output logic            lower_count_pin,
    output logic            upper_count_pin
);
    logic [10:0] cnt;
    // free-running prescaler chain
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) cnt <= 11'h0;
        else cnt <= cnt + 11'h1;
    end
    // taps pulse once per divided period
    assign tap_high = {&cnt, 1'b0, &cnt[6:0], 1'b0, &cnt[4:0], 1'b0, &cnt[2:0], cnt[0]};
    assign tap_low = &cnt[3:0];
    assign tap_low_div8 = &cnt[6:0];
    // falling edge every 32 and every 16 cycles
    assign lower_count_pin = cnt[4];
    assign upper_count_pin = cnt[3];
endmodule : ctp_far_side
`default_nettype wire

// *** bench/ctp_timer_pair_sva.sv ***
// Purpose: bus handshake and match checks
// Assumes: one clock, active-low reset
// Notes:   attached by bind below
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair_sva (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        lower_match_interrupt,
    input wire logic        lower_flipflop_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // write taken whole, then answered
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer; ##[1:3] s_axi_bvalid; endsequence
    property p_wr_answer; s_wr_taken |-> s_wr_answer; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write unanswered");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write accepted early");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted early");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_rdata_top; s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0; endproperty
    a_rdata_top: assert property (p_rdata_top) else $error("upper read bits set");
    // a match pulse goes with a flip-flop toggle
    property p_irq_ff; lower_match_interrupt |-> lower_flipflop_out != $past(lower_flipflop_out);
    endproperty
    a_irq_ff: assert property (p_irq_ff) else $error("match without toggle");
endmodule : ctp_timer_pair_sva
bind ctp_timer_pair ctp_timer_pair_sva i_ctp_timer_pair_sva (.*);
`default_nettype wire

// *** bench/ctp_timer_pair_tb.sv ***
// Purpose: self-checking bench for the timer pair
// Assumes: taps from ctp_far_side
// Notes:   period zero matches on each tick
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair_tb;
    logic        sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, tap_low, tap_low_div8;
    logic        lower_count_pin, upper_count_pin, lower_match_interrupt;
    logic        upper_match_interrupt, lower_flipflop_out, upper_flipflop_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, tap_high;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          failures = 0, total_checks = 0, cycles = 0, n;
    logic [31:0] tbl [13] = '{32'h800, 32'h1000080, 32'h2000080, 32'h10080, 32'h20020,
        32'h30008, 32'h40010, 32'h50002, 32'h60001, 32'h70020, 32'h10070010, 32'h2030000,
        32'h10030008};
    always #4 sys_clk = ~sys_clk;
    ctp_timer_pair i_ctp_timer_pair (.*);
    ctp_far_side i_ctp_far_side (.*);
    // compare and count
    task automatic chk(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // one bus write
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    // one bus read
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rdc
    // cycles between two match pulses, 0 if fewer than two
    task automatic gap(input logic up, output int g);
        int k = 0;
        int p = 0;
        g = 0;
        while (p < 2 && k < 6000) begin
            @(posedge sys_clk);
            k++;
            if (p > 0) g++;
            if ((up ? upper_match_interrupt : lower_match_interrupt) === 1'b1) p++;
        end
        if (p < 2) g = 0;
    endtask : gap
    task automatic t_regs();
        for (int i = 0; i < 6; i++)
            rdc(8'h60 + 8'(4 * i), (i < 2) ? 32'h0 : 32'hff, 2'b00);
        rdc(8'h00, 32'h0, 2'b10);
        wr(8'h80, 8'h12, 2'b10);
        wr(8'h64, 8'h5a, 2'b00);
        wr(8'h74, 8'h80, 2'b00);
        rdc(8'h64, 32'h5a, 2'b00);
        wr(8'h64, 8'h52, 2'b00);
        wr(8'h7c, 8'h55, 2'b00);
        rdc(8'h7c, 32'h0, 2'b00);
    endtask : t_regs
    task automatic t_timer8();
        wr(8'h68, 8'h03, 2'b00);
        wr(8'h60, 8'he0, 2'b00);
        repeat (2) @(posedge sys_clk);
        chk(32'(lower_flipflop_out), 32'h1);
        wr(8'h60, 8'he8, 2'b00);
        gap(1'b0, n);
        chk(32'(n), 32'h4);
        wr(8'h60, 8'he0, 2'b00);
        rdc(8'h7c, 32'h0001_0000, 2'b00);
        wr(8'h60, 8'h00, 2'b00);
        wr(8'h68, 8'h00, 2'b00);
        wr(8'h70, 8'h00, 2'b00);
    endtask : t_timer8
    // every clock select and option
    task automatic t_clocks();
        for (int i = 0; i < 13; i++) begin
            wr(8'h78, {6'h0, tbl[i][25:24]}, 2'b00);
            wr(tbl[i][28] ? 8'h64 : 8'h60, {1'b0, tbl[i][18:16], 4'h8}, 2'b00);
            gap(tbl[i][28], n);
            chk(32'(n), {16'h0, tbl[i][15:0]});
            wr(tbl[i][28] ? 8'h64 : 8'h60, {1'b0, tbl[i][18:16], 4'h0}, 2'b00);
        end
    endtask : t_clocks
    // cascade at fc, then warm-up in slow
    task automatic t_cascade();
        wr(8'h78, 8'h00, 2'b00);
        wr(8'h68, 8'h02, 2'b00);
        wr(8'h70, 8'h01, 2'b00);
        wr(8'h60, 8'h63, 2'b00);
        wr(8'h64, 8'h7c, 2'b00);
        gap(1'b1, n);
        chk(32'(n), 32'd259);
        wr(8'h64, 8'h74, 2'b00);
        wr(8'h78, 8'h02, 2'b00);
        wr(8'h64, 8'h1d, 2'b00);
        gap(1'b1, n);
        chk(32'(n), 32'd259);
        wr(8'h64, 8'h15, 2'b00);
        wr(8'h64, 8'h95, 2'b00);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, upper_flipflop_out, lower_flipflop_out}, 32'h3);
    endtask : t_cascade
    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        sys_clk = 0;
        resetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'h1;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_timer8();
        t_clocks();
        t_cascade();
        wrap_up();
    end
endmodule : ctp_timer_pair_tb
`default_nettype wire

// *** hdl/ctp_cfg.svh ***
// Purpose: offsets, field positions and reset values for the timer pair
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   definitions only
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH

`define CTP_OFS_LOWER_CTRL    8'h18
`define CTP_OFS_UPPER_CTRL    8'h19
`define CTP_IDX_UPPER_CTRL    8'h19
`define CTP_ADR_LOWER_CTRL    8'h60
`define CTP_ADR_UPPER_CTRL    8'h64
`define CTP_ADR_LOWER_PERIOD  8'h68
`define CTP_ADR_LOWER_WIDTH   8'h6c
`define CTP_ADR_UPPER_PERIOD  8'h70
`define CTP_ADR_UPPER_WIDTH   8'h74
`define CTP_ADR_OPTION        8'h78
`define CTP_ADR_STATUS        8'h7c

`define CTP_CTRL_RESET        8'h00
`define CTP_CMP_RESET         8'hff
`define CTP_FLD_FF            7
`define CTP_FLD_CK_HI         6
`define CTP_FLD_CK_LO         4
`define CTP_FLD_START         3
`define CTP_FLD_MODE_HI       2
`define CTP_FLD_MODE_LO       0

`define CTP_OPT_DIVSRC        0
`define CTP_OPT_SLOW          1

`define CTP_RESP_OKAY         2'b00
`define CTP_RESP_SLVERR       2'b10

`endif

// *** hdl/ctp_clock_select.sv ***
// Purpose: picks one count enable from prescaler taps and the count pin
// Assumes: taps are one-cycle enables in the sys_clk domain
// Notes:   the count pin is counted on its falling edge
`timescale 1ns/1ps
`default_nettype none
module ctp_clock_select
    import ctp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [2:0] clock_select,
    input  wire logic       divider_source_option,
    input  wire logic       slow_sleep,
    input  wire logic       warmup_mode,
    input  wire logic [7:0] tap_high,
    input  wire logic       tap_low,
    input  wire logic       tap_low_div8,
    input  wire logic       count_pin,
    output logic            tick
);
    logic pin_prev;
    logic next_pin_prev;

    // previous pin level for edge detect
    always_comb begin
        next_pin_prev = count_pin;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= next_pin_prev;
        end
    end

    // tap mux; high-frequency taps are dead in slow/sleep
    always_comb begin
        unique case (ctp_clk_e'(clock_select))
            CTP_CK_DIV11: tick = (divider_source_option || slow_sleep) ? tap_low_div8
                                                                        : tap_high[7]; // RQ2
            CTP_CK_DIV7:  tick = !slow_sleep && tap_high[5];   // RQ2
            CTP_CK_DIV5:  tick = !slow_sleep && tap_high[3];   // RQ2
            CTP_CK_DIV3:  tick = !slow_sleep && tap_high[1];   // RQ2
            CTP_CK_LOW:   tick = tap_low;                      // RQ2
            CTP_CK_DIV1:  tick = !slow_sleep && tap_high[0];   // RQ2
            CTP_CK_HIGH:  tick = !slow_sleep || warmup_mode;   // RQ13
            CTP_CK_PIN:   tick = pin_prev && !count_pin;       // RQ2
        endcase
    end
endmodule : ctp_clock_select
`default_nettype wire

// *** hdl/ctp_pkg.sv ***
// Purpose: types shared by the timer pair
// Assumes: nothing
// Notes:   encodings of mode and clock select
package ctp_pkg;

    typedef enum logic [2:0] {
        CTP_M_TIMER8   = 3'h0,
        CTP_M_DIVOUT8  = 3'h1,
        CTP_M_PWM8     = 3'h2,
        CTP_M_CASCADE  = 3'h3,
        CTP_M_TIMER16  = 3'h4,
        CTP_M_WARMUP   = 3'h5,
        CTP_M_PWM16    = 3'h6,
        CTP_M_PPG16    = 3'h7
    } ctp_mode_e;

    typedef enum logic [2:0] {
        CTP_CK_DIV11   = 3'h0,
        CTP_CK_DIV7    = 3'h1,
        CTP_CK_DIV5    = 3'h2,
        CTP_CK_DIV3    = 3'h3,
        CTP_CK_LOW     = 3'h4,
        CTP_CK_DIV1    = 3'h5,
        CTP_CK_HIGH    = 3'h6,
        CTP_CK_PIN     = 3'h7
    } ctp_clk_e;

    typedef logic [7:0] ctp_byte_t;

endpackage : ctp_pkg

// *** hdl/ctp_timer_pair.sv ***
// Purpose: control of two 8-bit timers that cascade into one 16-bit timer
// Assumes: prescaler taps arrive as one-cycle enables; inputs synchronous
// Notes:
// Notes on behaviour
// [RQ1] upper control: bit7 flip-flop, bits6:4 clock, bit3 start, bits2:0 mode; reset zero
// [RQ2] clock select picks prescaler tap, low clock or count pin
// [RQ3] start written 0 stops and clears the counter; 1 starts counting
// [RQ4] mode codes: 8-bit timer, divider, PWM, reserved, 16-bit modes
// [RQ5] software keeps mode, clock, flip-flop fields fixed while running
// [RQ6] stop write keeps other fields; start write may program them
// [RQ7] upper mode top bit set: upper counter clocked by lower overflow
// [RQ8] software sets lower mode to cascade code for 16-bit use
// [RQ9] 16-bit: clock from lower select; start and flip-flop from upper
// [RQ10] software leaves upper period compare alone while running
// [RQ11] upper width compare rewritten while running only in PWM modes
// [RQ12] each timer has control, period and width compare registers
// [RQ13] slow/sleep: undivided high clock only for warm-up mode
// [RQ14] counter matches period: interrupt pulse, clear, resume counting
// [RQ15] cascade: lower is low byte, upper high byte, paired compares
`timescale 1ns/1ps
`default_nettype none
`include "ctp_cfg.svh"
module ctp_timer_pair
    import ctp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  tap_high,
    input  wire logic        tap_low,
    input  wire logic        tap_low_div8,
    input  wire logic        lower_count_pin,
    input  wire logic        upper_count_pin,
    output logic             lower_match_interrupt,
    output logic             upper_match_interrupt,
    output logic             lower_flipflop_out,
    output logic             upper_flipflop_out
);
    // register file
    ctp_byte_t lower_timer_control, timer_four_control;
    ctp_byte_t lower_period_compare, lower_width_compare;
    ctp_byte_t upper_period_compare, upper_width_compare;
    logic [1:0] option;
    ctp_byte_t next_lower_timer_control, next_timer_four_control;
    ctp_byte_t next_lower_period_compare, next_lower_width_compare;
    ctp_byte_t next_upper_period_compare, next_upper_width_compare;
    logic [1:0] next_option;

    // bus handshake state
    logic        aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    // counting state
    ctp_byte_t lower_count, upper_count, next_lower_count, next_upper_count;
    logic      lower_irq, upper_irq, next_lower_irq, next_upper_irq;
    logic      lower_ff, upper_ff, next_lower_ff, next_upper_ff;

    logic      lower_tick, upper_tick_sel, upper_tick;
    logic      cascade, lower_run, upper_run, do_write;
    logic      lower_match, upper_match, cascade_match;
    logic [2:0] lower_mode, upper_mode;

    // field access
    function automatic logic field_start(input ctp_byte_t ctrl);
        field_start = ctrl[`CTP_FLD_START];
    endfunction : field_start

    function automatic logic [2:0] field_mode(input ctp_byte_t ctrl);
        field_mode = ctrl[`CTP_FLD_MODE_HI:`CTP_FLD_MODE_LO];
    endfunction : field_mode

    function automatic logic [2:0] field_clock(input ctp_byte_t ctrl);
        field_clock = ctrl[`CTP_FLD_CK_HI:`CTP_FLD_CK_LO];
    endfunction : field_clock

    // byte-lane merge of the low byte
    function automatic ctp_byte_t merge_byte(input ctp_byte_t old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
        merge_byte = strb[0] ? data[7:0] : old;
    endfunction : merge_byte

    // mode decode
    assign lower_mode = field_mode(lower_timer_control);
    assign upper_mode = field_mode(timer_four_control);                 // RQ4
    assign cascade    = upper_mode[2];                                  // RQ7
    assign upper_run  = field_start(timer_four_control);
    assign lower_run  = cascade ? upper_run                             // RQ9
                                : field_start(lower_timer_control);

    // source clock for lower timer; cascade uses its select too
    ctp_clock_select u_lower_clk (
        .sys_clk               (sys_clk),
        .resetn                (resetn),
        .clock_select          (field_clock(lower_timer_control)),      // RQ9
        .divider_source_option (option[`CTP_OPT_DIVSRC]),
        .slow_sleep            (option[`CTP_OPT_SLOW]),
        .warmup_mode           (upper_mode == CTP_M_WARMUP),
        .tap_high              (tap_high),
        .tap_low               (tap_low),
        .tap_low_div8          (tap_low_div8),
        .count_pin             (lower_count_pin),
        .tick                  (lower_tick)
    );

    ctp_clock_select u_upper_clk (
        .sys_clk               (sys_clk),
        .resetn                (resetn),
        .clock_select          (field_clock(timer_four_control)),
        .divider_source_option (option[`CTP_OPT_DIVSRC]),
        .slow_sleep            (option[`CTP_OPT_SLOW]),
        .warmup_mode           (1'b0),                                  // RQ13
        .tap_high              (tap_high),
        .tap_low               (tap_low),
        .tap_low_div8          (tap_low_div8),
        .count_pin             (upper_count_pin),
        .tick                  (upper_tick_sel)
    );

    // compare decode; cascade compares the 16-bit pair
    assign lower_match   = lower_count == lower_period_compare;
    assign upper_match   = upper_count == upper_period_compare;
    assign cascade_match = lower_match && upper_match;                  // RQ15
    assign upper_tick    = cascade ? (lower_run && lower_tick && lower_count == 8'hff) // RQ7
                                   : upper_tick_sel;

    // counters, match pulses and flip-flops
    always_comb begin
        next_lower_count = lower_count;
        next_upper_count = upper_count;
        next_lower_irq   = 1'b0;
        next_upper_irq   = 1'b0;
        next_lower_ff    = lower_ff;
        next_upper_ff    = upper_ff;
        if (!lower_run) begin
            next_lower_count = 8'h00;                                   // RQ3
            next_lower_ff    = lower_timer_control[`CTP_FLD_FF];
        end
        if (!upper_run) begin
            next_upper_count = 8'h00;                                   // RQ3
            next_upper_ff    = timer_four_control[`CTP_FLD_FF];         // RQ9
        end
        if (cascade) begin
            next_lower_ff = upper_ff;
            if (upper_run && lower_tick) begin
                if (cascade_match) begin
                    next_lower_count = 8'h00;                           // RQ14
                    next_upper_count = 8'h00;
                    next_upper_irq   = 1'b1;
                    next_upper_ff    = !upper_ff;
                end else begin
                    next_lower_count = lower_count + 8'h01;             // RQ15
                    if (upper_tick) begin
                        next_upper_count = upper_count + 8'h01;
                    end
                end
            end
        end else begin
            if (lower_run && lower_tick) begin
                if (lower_match) begin
                    next_lower_count = 8'h00;                           // RQ14
                    next_lower_irq   = 1'b1;
                    next_lower_ff    = !lower_ff;
                end else begin
                    next_lower_count = lower_count + 8'h01;
                end
            end
            if (upper_run && upper_tick) begin
                if (upper_match) begin
                    next_upper_count = 8'h00;                           // RQ14
                    next_upper_irq   = 1'b1;
                    next_upper_ff    = !upper_ff;
                end else begin
                    next_upper_count = upper_count + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lower_count <= 8'h00;
            upper_count <= 8'h00;
            lower_irq   <= 1'b0;
            upper_irq   <= 1'b0;
            lower_ff    <= 1'b0;
            upper_ff    <= 1'b0;
        end else begin
            lower_count <= next_lower_count;
            upper_count <= next_upper_count;
            lower_irq   <= next_lower_irq;
            upper_irq   <= next_upper_irq;
            lower_ff    <= next_lower_ff;
            upper_ff    <= next_upper_ff;
        end
    end

    // bus slave: capture address and data in either order, answer once both held
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;
    assign do_write      = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_lower_timer_control  = lower_timer_control;
        next_timer_four_control   = timer_four_control;
        next_lower_period_compare = lower_period_compare;
        next_lower_width_compare  = lower_width_compare;
        next_upper_period_compare = upper_period_compare;
        next_upper_width_compare  = upper_width_compare;
        next_option               = option;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // register write; fields stored as written
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `CTP_RESP_OKAY;
            unique case ({aw_addr[7:2], 2'b00})
                `CTP_ADR_LOWER_CTRL:   next_lower_timer_control =
                    merge_byte(lower_timer_control, w_data, w_strb);      // RQ12
                `CTP_ADR_UPPER_CTRL:   next_timer_four_control =
                    merge_byte(timer_four_control, w_data, w_strb);       // RQ1
                `CTP_ADR_LOWER_PERIOD: next_lower_period_compare =
                    merge_byte(lower_period_compare, w_data, w_strb);     // RQ12
                `CTP_ADR_LOWER_WIDTH:  next_lower_width_compare =
                    merge_byte(lower_width_compare, w_data, w_strb);
                `CTP_ADR_UPPER_PERIOD: next_upper_period_compare =
                    merge_byte(upper_period_compare, w_data, w_strb);
                `CTP_ADR_UPPER_WIDTH:  next_upper_width_compare =
                    merge_byte(upper_width_compare, w_data, w_strb);
                `CTP_ADR_OPTION:       next_option = w_strb[0] ? w_data[1:0] : option;
                `CTP_ADR_STATUS:       next_bresp = `CTP_RESP_OKAY;   // read-only
                default:               next_bresp = `CTP_RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // register read
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `CTP_RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `CTP_ADR_LOWER_CTRL:   next_rdata[7:0] = lower_timer_control;
                `CTP_ADR_UPPER_CTRL:   next_rdata[7:0] = timer_four_control;
                `CTP_ADR_LOWER_PERIOD: next_rdata[7:0] = lower_period_compare;
                `CTP_ADR_LOWER_WIDTH:  next_rdata[7:0] = lower_width_compare;
                `CTP_ADR_UPPER_PERIOD: next_rdata[7:0] = upper_period_compare;
                `CTP_ADR_UPPER_WIDTH:  next_rdata[7:0] = upper_width_compare;
                `CTP_ADR_OPTION:       next_rdata[1:0] = option;
                `CTP_ADR_STATUS:       next_rdata[17:0] = {upper_ff, lower_ff,
                                           upper_count, lower_count};
                default:               next_rresp = `CTP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `CTP_RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= `CTP_RESP_OKAY;
            rdata   <= 32'h0000_0000;
            lower_timer_control  <= `CTP_CTRL_RESET;
            timer_four_control   <= `CTP_CTRL_RESET;                    // RQ1
            lower_period_compare <= `CTP_CMP_RESET;
            lower_width_compare  <= `CTP_CMP_RESET;
            upper_period_compare <= `CTP_CMP_RESET;
            upper_width_compare  <= `CTP_CMP_RESET;
            option               <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            lower_timer_control  <= next_lower_timer_control;
            timer_four_control   <= next_timer_four_control;
            lower_period_compare <= next_lower_period_compare;
            lower_width_compare  <= next_lower_width_compare;
            upper_period_compare <= next_upper_period_compare;
            upper_width_compare  <= next_upper_width_compare;
            option               <= next_option;
        end
    end

    // outputs from flops
    assign lower_match_interrupt = lower_irq;   // RQ14
    assign upper_match_interrupt = upper_irq;
    assign lower_flipflop_out    = lower_ff;
    assign upper_flipflop_out    = upper_ff;
endmodule : ctp_timer_pair
`default_nettype wire
